// [core/eltc_map.vh]
// Register map and field layout of the link-training control block.
// Assumes a 32-bit AHB-Lite slave; byte address is four times the index.
`ifndef ELTC_MAP_VH
`define ELTC_MAP_VH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define ELTC_IDX_CFG 12'h04d0
`define ELTC_IDX_CMD 12'h04d1
`define ELTC_IDX_STAT 12'h04d2
`define ELTC_IDX_COEF 12'h04d4

// ----------------------------------------------------------------------
// Config fields
// ----------------------------------------------------------------------
`define ELTC_CFG_TRAIN_EN 0
`define ELTC_CFG_NO_WAIT 1
`define ELTC_CFG_HYST 14:12
`define ELTC_CFG_NO_INIT 15
`define ELTC_CFG_PART_OVR 16
`define ELTC_CFG_LOC_OVR 17
`define ELTC_CFG_SWING 18
`define ELTC_CFG_DFE_BYP 19
`define ELTC_CFG_FREEZE 21:20
`define ELTC_CFG_GAIN_MAN 22
`define ELTC_CFG_CTLE 28:24
`define ELTC_CFG_VGA 31:29
`define ELTC_CFG_WMASK 32'hff7f_f003

// Reset images: hardware and simulation flavours
`define ELTC_CFG_RST_HW 32'he110_5001
`define ELTC_CFG_RST_SIM 32'h8158_5001

// ----------------------------------------------------------------------
// Command, status and coefficient fields
// ----------------------------------------------------------------------
`define ELTC_CMD_RESTART 0
`define ELTC_CMD_NEW_PART 4
`define ELTC_CMD_NEW_LOC 8
`define ELTC_ST_TRAINED 0
`define ELTC_ST_BUSY 2
`define ELTC_ST_FAIL 3
`define ELTC_COEF_PART 7:0
`define ELTC_COEF_LOC 23:16
`define ELTC_COEF_WMASK 32'h00ff_00ff

// Coefficient update command codes and the tap-hold freeze-all code
`define ELTC_UPD_HOLD 2'b00
`define ELTC_UPD_INC 2'b01
`define ELTC_UPD_DEC 2'b10
`define ELTC_FRZ_ALL 2'b01

// Maximum wait, in milliseconds, and the clock rate
`define ELTC_WAIT_MS 500
`define ELTC_CLK_KHZ 100000

`endif

// [core/eltc_ctrl.v]
// Software control of the backplane link-training engine.
// Assumes an AHB-Lite master on clk_sys and training logic beside it.
//
// Contract
// - hysteresis field code selects 0 to 128
// - disable bit skips transmit init on failure
// - wait timer expiry sets training failure
// - partner override sends software update commands
// - local override lets software set coefficients
// - swing bit enables partner main-tap adjustment
// - bypass bit turns off adaptive DFE
// - tap-hold field freezes none or all
// - tap-hold applies only without DFE bypass
// - gain mode picks CTLE sweep or manual
// - manual CTLE used only in manual mode
// - manual VGA used only in manual mode
// - restart bit resets training, self-clears
// - new partner bit sends coefficient bits 5:0
// - new local bit applies coefficient bits 21:16
// - wait-limit disable bit stops wait timer
// - training enable bit runs start-up protocol
// - update codes: 01 inc, 10 dec, 00 hold
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "eltc_map.vh"

module eltc_ctrl #(
    parameter SIM_DEFAULTS = 0,
    parameter WAIT_CYCLES = `ELTC_WAIT_MS * `ELTC_CLK_KHZ
) (
    input wire clk_sys, // System clock, 100 MHz
    input wire nrst, // Asynchronous reset, active low
    input wire hsel, // AHB slave select
    input wire [31:0] haddr, // AHB address
    input wire [1:0] htrans, // AHB transfer type
    input wire hwrite, // AHB write flag
    input wire [2:0] hsize, // AHB transfer size
    input wire hready, // AHB bus ready
    input wire [31:0] hwdata, // AHB write data
    output reg [31:0] hrdata, // AHB read data
    output reg hreadyout, // AHB slave ready
    output reg hresp, // AHB response, always OKAY
    input wire [5:0] train_logic_cmd, // Derived partner commands
    input wire train_logic_done, // Training logic finished
    input wire [5:0] lp_cmd_pin, // Commands received from partner
    output reg [5:0] part_cmd_out, // Commands sent to partner
    output reg part_cmd_stb, // Partner command strobe
    output reg [5:0] loc_cmd_out, // Local transmit equalizer update
    output reg loc_cmd_stb, // Local update strobe
    output reg pma_init, // Initialize swing, pre and post taps
    output reg train_run, // Start-up protocol running
    output reg train_fail, // Training failure status
    output reg [7:0] hyst_val, // Error-count hysteresis
    output reg dfe_bypass, // Bypass adaptive DFE after training
    output reg dfe_freeze, // Freeze all DFE taps after training
    output reg ctle_sweep, // Sweep CTLE before transmit EQ
    output reg gain_manual, // Hold manual CTLE and VGA
    output reg [4:0] ctle_val, // Manual CTLE value
    output reg [2:0] vga_val // Manual VGA value
);

    localparam [31:0] CFG_RST = SIM_DEFAULTS ? `ELTC_CFG_RST_SIM :
        `ELTC_CFG_RST_HW;
    localparam [31:0] WAIT_MAX = WAIT_CYCLES - 1;
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_TRAIN = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    localparam [1:0] ST_FAIL = 2'b11;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // Partner command pins
    // ------------------------------------------------------------------
    // Partner commands come from the link, so two flops before use
    reg [5:0] lp_meta_reg;
    reg [5:0] lp_cmd_reg;
    reg [5:0] lp_prev_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lp_meta_reg <= 6'h00;
            lp_cmd_reg <= 6'h00;
            lp_prev_reg <= 6'h00;
        end else begin
            lp_meta_reg <= lp_cmd_pin;
            lp_cmd_reg <= lp_meta_reg;
            lp_prev_reg <= lp_cmd_reg;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    reg [31:0] cfg_reg;
    reg [31:0] coef_reg;
    reg wr_pend_reg;
    reg [11:0] wr_idx_reg;
    reg restart_pend_reg;
    reg part_pend_reg;
    reg loc_pend_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    wire acc;
    wire [11:0] idx;
    wire wr_cfg;
    wire wr_cmd;
    wire wr_coef;
    reg [31:0] rd_next;

    assign acc = hsel & hready & htrans[1];
    assign idx = haddr[13:2];
    assign wr_cfg = wr_pend_reg & (wr_idx_reg == `ELTC_IDX_CFG);
    assign wr_cmd = wr_pend_reg & (wr_idx_reg == `ELTC_IDX_CMD);
    assign wr_coef = wr_pend_reg & (wr_idx_reg == `ELTC_IDX_COEF);

    // Read data is picked in the address phase so the answer is a flop
    always @* begin
        rd_next = 32'h0000_0000;
        case (idx)
            `ELTC_IDX_CFG: rd_next = cfg_reg;
            `ELTC_IDX_CMD: begin
                rd_next[`ELTC_CMD_RESTART] = restart_pend_reg;
                rd_next[`ELTC_CMD_NEW_PART] = part_pend_reg;
                rd_next[`ELTC_CMD_NEW_LOC] = loc_pend_reg;
            end
            `ELTC_IDX_STAT: begin
                rd_next[`ELTC_ST_TRAINED] = (state_reg == ST_DONE);
                rd_next[`ELTC_ST_BUSY] = (state_reg == ST_TRAIN);
                rd_next[`ELTC_ST_FAIL] = (state_reg == ST_FAIL);
            end
            `ELTC_IDX_COEF: rd_next = coef_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= acc & hwrite;
            if (acc) begin
                wr_idx_reg <= idx;
            end
            if (acc & ~hwrite) begin
                hrdata <= rd_next;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Config and coefficient registers; reserved config bits read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= CFG_RST;
            coef_reg <= 32'h0000_0000;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= hwdata & `ELTC_CFG_WMASK;
            end
            if (wr_coef) begin
                coef_reg <= hwdata & `ELTC_COEF_WMASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Self-clearing commands
    // ------------------------------------------------------------------
    // A command holds for one cycle only; writing zero does nothing
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            restart_pend_reg <= 1'b0;
            part_pend_reg <= 1'b0;
            loc_pend_reg <= 1'b0;
        end else begin
            restart_pend_reg <= wr_cmd & hwdata[`ELTC_CMD_RESTART];
            part_pend_reg <= wr_cmd & hwdata[`ELTC_CMD_NEW_PART];
            loc_pend_reg <= wr_cmd & hwdata[`ELTC_CMD_NEW_LOC];
        end
    end

    // ------------------------------------------------------------------
    // Start-up protocol and maximum wait timer
    // ------------------------------------------------------------------
    reg [31:0] wait_reg;
    wire wait_done;

    assign wait_done = (wait_reg == WAIT_MAX) &
        ~cfg_reg[`ELTC_CFG_NO_WAIT];

    always @* begin
        case (state_reg)
            ST_IDLE: state_next = ST_TRAIN;
            ST_TRAIN: begin
                if (train_logic_done) begin
                    state_next = ST_DONE;
                end else if (wait_done) begin
                    state_next = ST_FAIL;
                end else begin
                    state_next = ST_TRAIN;
                end
            end
            ST_DONE: state_next = ST_DONE;
            ST_FAIL: state_next = ST_FAIL;
            default: state_next = ST_IDLE;
        endcase
        if (restart_pend_reg) begin
            state_next = ST_IDLE;
        end
        if (!cfg_reg[`ELTC_CFG_TRAIN_EN]) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            wait_reg <= 32'h0000_0000;
            pma_init <= 1'b0;
            train_run <= 1'b0;
            train_fail <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != ST_TRAIN || state_reg != ST_TRAIN) begin
                wait_reg <= 32'h0000_0000;
            end else if (!cfg_reg[`ELTC_CFG_NO_WAIT] && !wait_done) begin
                wait_reg <= wait_reg + 32'h0000_0001;
            end
            // Taps are re-initialized only on entry to failure
            pma_init <= (state_next == ST_FAIL) & (state_reg != ST_FAIL) &
                ~cfg_reg[`ELTC_CFG_NO_INIT];
            train_run <= (state_next == ST_TRAIN);
            train_fail <= (state_next == ST_FAIL);
        end
    end

    // ------------------------------------------------------------------
    // Coefficient update paths
    // ------------------------------------------------------------------
    reg [5:0] derived_cmd;
    wire lp_new;

    // Main-tap command is held when swing training is off
    always @* begin
        derived_cmd = train_logic_cmd;
        if (!cfg_reg[`ELTC_CFG_SWING]) begin
            derived_cmd[3:2] = `ELTC_UPD_HOLD;
        end
    end

    assign lp_new = (lp_cmd_reg != lp_prev_reg) &
        (lp_cmd_reg != {3{`ELTC_UPD_HOLD}});

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            part_cmd_out <= {3{`ELTC_UPD_HOLD}};
            part_cmd_stb <= 1'b0;
            loc_cmd_out <= {3{`ELTC_UPD_HOLD}};
            loc_cmd_stb <= 1'b0;
        end else begin
            if (cfg_reg[`ELTC_CFG_PART_OVR]) begin
                part_cmd_stb <= part_pend_reg;
                if (part_pend_reg) begin
                    part_cmd_out <= coef_reg[5:0];
                end
            end else begin
                part_cmd_stb <= train_run;
                part_cmd_out <= derived_cmd;
            end
            // Command bits without the override are dropped
            if (cfg_reg[`ELTC_CFG_LOC_OVR]) begin
                loc_cmd_stb <= loc_pend_reg;
                if (loc_pend_reg) begin
                    loc_cmd_out <= coef_reg[21:16];
                end
            end else begin
                loc_cmd_stb <= lp_new;
                loc_cmd_out <= lp_cmd_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Equalizer and gain controls
    // ------------------------------------------------------------------
    wire [2:0] hyst_code;
    wire man;

    assign hyst_code = cfg_reg[`ELTC_CFG_HYST];
    assign man = cfg_reg[`ELTC_CFG_GAIN_MAN];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hyst_val <= 8'h00;
            dfe_bypass <= 1'b0;
            dfe_freeze <= 1'b0;
            ctle_sweep <= 1'b0;
            gain_manual <= 1'b0;
            ctle_val <= 5'h00;
            vga_val <= 3'h0;
        end else begin
            // Code 0 means none, otherwise two to the code
            hyst_val <= (hyst_code == 3'h0) ? 8'h00 :
                (8'h01 << hyst_code);
            dfe_bypass <= cfg_reg[`ELTC_CFG_DFE_BYP];
            // Reserved freeze codes freeze nothing
            dfe_freeze <= ~cfg_reg[`ELTC_CFG_DFE_BYP] &
                (cfg_reg[`ELTC_CFG_FREEZE] == `ELTC_FRZ_ALL);
            ctle_sweep <= ~man;
            gain_manual <= man;
            ctle_val <= man ? cfg_reg[`ELTC_CFG_CTLE] : 5'h00;
            vga_val <= man ? cfg_reg[`ELTC_CFG_VGA] : 3'h0;
        end
    end
    // Tap-hold decode above, hardware resets to freeze all
    // without local override the new-local bit is ignored

endmodule // eltc_ctrl

// [bench/eltc_ctrl_checker.sv]
// Port checker for the link-training control block.
// Assumes it is bound onto eltc_ctrl and sees only its ports.
`timescale 1ns/1ps
module eltc_ctrl_checker (
    input wire clk_sys, // Clock
    input wire nrst, // Reset, active low
    input wire hreadyout, // Slave ready
    input wire hresp, // Slave response
    input wire [5:0] part_cmd_out, // Commands to partner
    input wire part_cmd_stb, // Partner strobe
    input wire pma_init, // Transmit init pulse
    input wire train_run, // Training running
    input wire train_fail, // Training failed
    input wire [7:0] hyst_val, // Hysteresis
    input wire dfe_bypass, // DFE bypass
    input wire dfe_freeze, // DFE freeze
    input wire ctle_sweep, // CTLE sweep mode
    input wire gain_manual, // Manual gain mode
    input wire [4:0] ctle_val, // Manual CTLE
    input wire [2:0] vga_val // Manual VGA
);
// ------
// Properties
// ------
reg [3:0] live_reg;
// Outputs leave their reset values three edges after nrst rises
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        live_reg <= 4'h0;
    end else begin
        live_reg <= {live_reg[2:0], 1'b1};
    end
end
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!live_reg[3]);
a_hyst_power: assert property ($onehot0(hyst_val) && !hyst_val[0])
    else $error("hysteresis is not zero or a power of two");
a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
a_fail_entry: assert property ($rose(train_fail) |-> $past(train_run))
    else $error("failure entered without running training");
a_state_excl: assert property (!(train_run && train_fail))
    else $error("running and failed at once");
a_init_pulse: assert property (pma_init |=> !pma_init)
    else $error("transmit init longer than one cycle");
a_init_fail: assert property (pma_init |-> ##[0:2] train_fail)
    else $error("transmit init outside failure entry");
a_freeze_byp: assert property (dfe_freeze |-> !dfe_bypass)
    else $error("taps frozen while DFE bypassed");
a_gain_mode: assert property (gain_manual != ctle_sweep)
    else $error("sweep and manual gain disagree");
a_manual_off: assert property (!gain_manual |-> ctle_val == 5'h0
    && vga_val == 3'h0)
    else $error("manual values driven outside manual mode");
a_upd_codes: assert property (part_cmd_stb |-> part_cmd_out[5:4] != 2'b11
    && part_cmd_out[3:2] != 2'b11 && part_cmd_out[1:0] != 2'b11)
    else $error("reserved update code sent");
endmodule // eltc_ctrl_checker

bind eltc_ctrl eltc_ctrl_checker u_eltc_ctrl_checker (
    .clk_sys(clk_sys), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
    .part_cmd_out(part_cmd_out), .part_cmd_stb(part_cmd_stb),
    .pma_init(pma_init), .train_run(train_run), .train_fail(train_fail),
    .hyst_val(hyst_val), .dfe_bypass(dfe_bypass), .dfe_freeze(dfe_freeze),
    .ctle_sweep(ctle_sweep), .gain_manual(gain_manual),
    .ctle_val(ctle_val), .vga_val(vga_val));

// [bench/eltc_lp_model.sv]
// Link partner stand-in: sends update commands, records what it got.
// Assumes commands cross on clk_sys as levels qualified by a strobe.
`timescale 1ns/1ps
module eltc_lp_model (
    input wire clk_sys, // Clock
    input wire nrst, // Reset, active low
    input wire [5:0] part_cmd_out, // Commands from the device
    input wire part_cmd_stb, // Strobe for those commands
    input wire [5:0] lp_send, // Commands the bench wants sent
    output reg [5:0] lp_cmd_pin, // Commands toward the device
    output reg [5:0] lp_last // Last strobed command received
);
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        lp_cmd_pin <= 6'h00;
        lp_last <= 6'h00;
    end else begin
        lp_cmd_pin <= lp_send;
        if (part_cmd_stb === 1'b1) begin
            lp_last <= part_cmd_out;
        end
    end
end
endmodule // eltc_lp_model

// [bench/eq_link_training_ctrl_tb_top.sv]
// Bench for the link-training control block over AHB-Lite.
// Assumes a 100 MHz clk_sys and a shortened wait limit of 20 cycles.
`timescale 1ns/1ps
`include "eltc_map.vh"
module eq_link_training_ctrl_tb_top;
localparam [31:0] A_CFG = `ELTC_IDX_CFG * 4;
localparam [31:0] A_CMD = `ELTC_IDX_CMD * 4;
localparam [31:0] A_STAT = `ELTC_IDX_STAT * 4;
localparam [31:0] A_COEF = `ELTC_IDX_COEF * 4;
reg clk_sys, nrst, hsel, hwrite, train_logic_done;
reg [31:0] haddr, hwdata, rd;
reg [1:0] htrans;
reg [2:0] hsize;
reg [5:0] train_logic_cmd, lp_send;
wire [31:0] hrdata;
wire hreadyout, hresp, part_cmd_stb, loc_cmd_stb, pma_init, train_run;
wire train_fail, dfe_bypass, dfe_freeze, ctle_sweep, gain_manual;
wire [5:0] part_cmd_out, loc_cmd_out, lp_cmd_pin, lp_last;
wire [7:0] hyst_val;
wire [4:0] ctle_val;
wire [2:0] vga_val;
integer errors, checks_done, pma_seen, i;
// ------
// Design and partner
// ------
eltc_ctrl #(.SIM_DEFAULTS(0), .WAIT_CYCLES(20)) u_eltc_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .train_logic_cmd(train_logic_cmd), .train_logic_done(train_logic_done),
    .lp_cmd_pin(lp_cmd_pin), .part_cmd_out(part_cmd_out),
    .part_cmd_stb(part_cmd_stb), .loc_cmd_out(loc_cmd_out),
    .loc_cmd_stb(loc_cmd_stb), .pma_init(pma_init), .train_run(train_run),
    .train_fail(train_fail), .hyst_val(hyst_val), .dfe_bypass(dfe_bypass),
    .dfe_freeze(dfe_freeze), .ctle_sweep(ctle_sweep),
    .gain_manual(gain_manual), .ctle_val(ctle_val), .vga_val(vga_val));
eltc_lp_model u_eltc_lp_model (
    .clk_sys(clk_sys), .nrst(nrst), .part_cmd_out(part_cmd_out),
    .part_cmd_stb(part_cmd_stb), .lp_send(lp_send),
    .lp_cmd_pin(lp_cmd_pin), .lp_last(lp_last));
// ------
// Tasks
// ------
task check(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task wrap_up;
    begin
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
// Bounded wait: 0 partner strobe, 1 local strobe, 2 failure, 3 ready
task wait_for(input integer sel);
    integer n;
    reg s;
    begin
        for (n = 0; n < 60; n = n + 1) begin
            @(posedge clk_sys);
            s = sel == 0 ? part_cmd_stb : sel == 1 ? loc_cmd_stb :
                sel == 2 ? train_fail : hreadyout;
            if (s === 1'b1) break;
        end
        if (n == 60) begin
            check(32'h0000_0000, 32'h0000_0001);
            wrap_up;
        end
    end
endtask
task bus(input w, input [31:0] a, input [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_for(3);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_for(3);
        rd = hrdata;
    end
endtask
// ------
// Stimulus
// ------
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) begin
    if (pma_init === 1'b1) pma_seen = pma_seen + 1;
end
initial begin
    errors = 0;
    checks_done = 0;
    pma_seen = 0;
    nrst = 1'b0;
    {hsel, hwrite, train_logic_done, haddr, hwdata, htrans} = 0;
    hsize = 3'b010;
    train_logic_cmd = 6'h00;
    lp_send = 6'h00;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, A_CFG, 0);
    check(rd, `ELTC_CFG_RST_HW);
    check({hyst_val, dfe_freeze, dfe_bypass, gain_manual, vga_val},
        {8'd32, 3'b100, 3'd0});
    wait_for(2);
    repeat (2) @(posedge clk_sys);
    check(pma_seen, 1);
    bus(0, A_STAT, 0);
    check(rd & 32'h0000_000d, 32'h0000_0008);
    for (i = 0; i < 8; i = i + 1) begin
        bus(1, A_CFG, 32'h1 | (i << 12) | (i[0] << 19) | (i[2:1] << 20));
        repeat (2) @(posedge clk_sys);
        check(hyst_val, (i == 0) ? 0 : (1 << i));
        check({dfe_bypass, dfe_freeze},
            {i[0], ~i[0] & (i[2:1] == 2'b01)});
    end
    bus(1, A_CFG, 32'h7540_0001);
    repeat (2) @(posedge clk_sys);
    check({gain_manual, ctle_sweep, ctle_val, vga_val},
        {2'b10, 5'h15, 3'd3});
    bus(0, A_CFG, 0);
    check(rd, 32'h7540_0001);
    bus(1, A_CFG, 32'h0000_8001);
    pma_seen = 0;
    bus(1, A_CMD, 32'h0000_0001);
    // The pending bit stands one cycle after the write lands
    @(posedge clk_sys);
    bus(0, A_CMD, 0);
    check(rd, 0);
    repeat (2) @(posedge clk_sys);
    check(train_run, 1);
    wait_for(2);
    repeat (2) @(posedge clk_sys);
    check(pma_seen, 0);
    train_logic_cmd <= 6'h15;
    bus(1, A_CFG, 32'h0000_0003);
    bus(1, A_CMD, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    check({train_fail, train_run, part_cmd_stb, part_cmd_out},
        {3'b011, 6'h11});
    bus(1, A_CFG, 32'h0004_0003);
    repeat (3) @(posedge clk_sys);
    check(part_cmd_out, 6'h15);
    train_logic_done <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, A_STAT, 0);
    check(rd & 32'h0000_000d, 32'h0000_0001);
    train_logic_done <= 1'b0;
    bus(1, A_COEF, 32'h0009_0006);
    bus(1, A_CFG, 32'h0003_0003);
    bus(1, A_CMD, 32'h0000_0010);
    wait_for(0);
    @(posedge clk_sys);
    check(lp_last, 6'h06);
    bus(1, A_CMD, 32'h0000_0100);
    wait_for(1);
    check(loc_cmd_out, 6'h09);
    bus(0, A_CMD, 0);
    check(rd, 0);
    bus(1, A_CFG, 32'h0000_0003);
    lp_send <= 6'h04;
    wait_for(1);
    check(loc_cmd_out, 6'h04);
    bus(1, A_CFG, 32'h0000_0002);
    bus(1, A_CMD, 32'h0000_0001);
    repeat (5) @(posedge clk_sys);
    check(train_run, 0);
    bus(0, 32'h0000_1360, 0);
    check(rd, 0);
    wrap_up;
end
endmodule // eq_link_training_ctrl_tb_top
